// ### common/mopalu_defines.vh
`ifndef MOPALU_DEFINES_VH
`define MOPALU_DEFINES_VH

// ***************************************
// Operation codes
// ***************************************
`define MOPALU_OP_NONE      4'h0
`define MOPALU_OP_INV_MEM   4'h1
`define MOPALU_OP_INV_WR    4'h2
`define MOPALU_OP_BCD_ADJ   4'h3
`define MOPALU_OP_DEC_MEM   4'h4
`define MOPALU_OP_DEC_WR    4'h5
`define MOPALU_OP_PWR_DOWN  4'h6
`define MOPALU_OP_INC_MEM   4'h7
`define MOPALU_OP_INC_WR    4'h8
`define MOPALU_OP_GOTO      4'h9

// ***************************************
// Constants and reset values
// ***************************************
`define MOPALU_NIBBLE_MAX   4'h9
`define MOPALU_BCD_LO_FIX   8'h06
`define MOPALU_BCD_HI_FIX   8'h60
`define MOPALU_WR_RESET     8'h00
`define MOPALU_PC_RESET     12'h000
`define MOPALU_GOTO_CYCLES  2'h2

`endif

// ### logic/mopalu_core.v
// Functional notes
// - invert_mem writes the inverted memory byte back and updates only the zero flag.
// - invert_to_working loads the inverted memory byte into the working register, memory untouched.
// - bcd_adjust adds 6 to the low nibble when it exceeds 9 or the nibble overflow flag is set.
// - The bcd_adjust correction is one of 00H, 06H, 60H or 66H added to the working register.
// - bcd_adjust writes its corrected sum to the addressed memory byte, not the working register.
// - bcd_adjust changes only the overflow-out flag, set when the decimal sum reaches 100.
// - mem_minus_one writes memory minus one back to memory and updates the zero flag.
// - minus_one_to_working loads memory minus one into the working register and updates zero flag.
// - power_down_op stops execution and the system clock while keeping all contents.
// - power_down_op clears the watchdog counter and its prescaler.
// - power_down_op sets the power-down flag and clears the timeout flag, no other flag.
// - mem_plus_one writes memory plus one back to memory and updates the zero flag.
// - plus_one_to_working loads memory plus one into the working register and updates zero flag.
// - goto_target loads the program counter with the target and takes two cycles.
`timescale 1ns/1ps
`default_nettype none
`include "mopalu_defines.vh"

module mopalu_core (
    // Clock and reset
    input  wire        ref_clk_i,
    input  wire        nrst_i,
    // Instruction issue
    input  wire        op_valid_i,
    input  wire [3:0]  op_code_i,
    input  wire [11:0] target_addr_i,
    // Operand and flags in
    input  wire [7:0]  mem_rdata_i,
    input  wire        nibble_overflow_flag_i,
    input  wire        overflow_out_flag_i,
    input  wire        wake_i,
    // Data memory write
    output reg         mem_we_o,
    output reg  [7:0]  mem_wdata_o,
    // Architectural state
    output reg  [7:0]  working_register_o,
    output reg  [11:0] pc_o,
    // Flag updates
    output reg         result_null_flag_o,
    output reg         result_null_we_o,
    output reg         overflow_out_flag_o,
    output reg         overflow_out_we_o,
    output reg         power_down_flag_o,
    output reg         watchdog_timeout_flag_o,
    output reg         watchdog_clear_o,
    // Sequencing
    output wire        busy_o,
    output reg         clk_gate_off_o
);

// ***************************************
// Sequencer states
// ***************************************
localparam ST_RUN   = 2'b00;
localparam ST_DUMMY = 2'b01;
localparam ST_HALT  = 2'b10;

reg  [1:0] state;
reg  [1:0] next_state;

// ***************************************
// Combinational results
// ***************************************
wire [7:0] inv_res = ~mem_rdata_i;
wire [7:0] dec_res = mem_rdata_i - 8'h01;
wire [7:0] inc_res = mem_rdata_i + 8'h01;

// ***************************************
// Zero detection
// ***************************************
wire       inv_zero = (inv_res == 8'h00);
wire       dec_zero = (dec_res == 8'h00);
wire       inc_zero = (inc_res == 8'h00);

// ***************************************
// Decimal adjust
// ***************************************
// High fix also catches a low-nibble carry into a 9
reg  [7:0] bcd_fix;
reg  [8:0] bcd_sum;
reg        lo_adj;
reg        hi_adj;
reg  [4:0] lo_sum;

always @* begin
    lo_adj = (working_register_o[3:0] > `MOPALU_NIBBLE_MAX)
             || nibble_overflow_flag_i;
    lo_sum = {1'b0, working_register_o[3:0]} + (lo_adj ? 5'h06 : 5'h00);
    hi_adj = (working_register_o[7:4] > `MOPALU_NIBBLE_MAX) || overflow_out_flag_i
             || ((working_register_o[7:4] == `MOPALU_NIBBLE_MAX) && lo_sum[4]);
    bcd_fix = (lo_adj ? `MOPALU_BCD_LO_FIX : 8'h00)
              | (hi_adj ? `MOPALU_BCD_HI_FIX : 8'h00);
    bcd_sum = {1'b0, working_register_o} + {1'b0, bcd_fix};
end

// ***************************************
// Issue decode
// ***************************************
wire issue       = op_valid_i && (state == ST_RUN);
wire op_goto     = (op_code_i == `MOPALU_OP_GOTO);
wire op_pwr_down = (op_code_i == `MOPALU_OP_PWR_DOWN);
assign busy_o    = (state != ST_RUN);

// ***************************************
// Sequencer
// ***************************************
always @* begin
    case (state)
        ST_RUN: begin
            if (issue && op_goto)
                next_state = ST_DUMMY;
            else if (issue && op_pwr_down)
                next_state = ST_HALT;
            else
                next_state = ST_RUN;
        end
        ST_DUMMY: next_state = ST_RUN;
        ST_HALT: begin
            // Only wake_i leaves power-down; contents stay frozen
            if (wake_i)
                next_state = ST_RUN;
            else
                next_state = ST_HALT;
        end
        default: next_state = ST_RUN;
    endcase
end

// ***************************************
// Sequencer state register
// ***************************************
always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
        state <= ST_RUN;
    end else begin
        state <= next_state;
    end
end

// ***************************************
// Datapath registers
// ***************************************
always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
        mem_we_o                <= 1'b0;
        mem_wdata_o             <= 8'h00;
        working_register_o      <= `MOPALU_WR_RESET;
        pc_o                    <= `MOPALU_PC_RESET;
        result_null_flag_o      <= 1'b0;
        result_null_we_o        <= 1'b0;
        overflow_out_flag_o     <= 1'b0;
        overflow_out_we_o       <= 1'b0;
        power_down_flag_o       <= 1'b0;
        watchdog_timeout_flag_o <= 1'b0;
        watchdog_clear_o        <= 1'b0;
        clk_gate_off_o          <= 1'b0;
    end else begin
        mem_we_o          <= 1'b0;
        result_null_we_o  <= 1'b0;
        overflow_out_we_o <= 1'b0;
        watchdog_clear_o  <= 1'b0;
        clk_gate_off_o    <= (next_state == ST_HALT);
        if (issue) begin
            case (op_code_i)
                `MOPALU_OP_INV_MEM: begin
                    mem_we_o           <= 1'b1;
                    mem_wdata_o        <= inv_res;
                    result_null_we_o   <= 1'b1;
                    result_null_flag_o <= inv_zero;
                end
                `MOPALU_OP_INV_WR: begin
                    working_register_o <= inv_res;
                    result_null_we_o   <= 1'b1;
                    result_null_flag_o <= inv_zero;
                end
                `MOPALU_OP_BCD_ADJ: begin
                    mem_we_o            <= 1'b1;
                    mem_wdata_o         <= bcd_sum[7:0];
                    overflow_out_we_o   <= 1'b1;
                    overflow_out_flag_o <= bcd_sum[8] || hi_adj;
                end
                `MOPALU_OP_DEC_MEM: begin
                    mem_we_o           <= 1'b1;
                    mem_wdata_o        <= dec_res;
                    result_null_we_o   <= 1'b1;
                    result_null_flag_o <= dec_zero;
                end
                `MOPALU_OP_DEC_WR: begin
                    working_register_o <= dec_res;
                    result_null_we_o   <= 1'b1;
                    result_null_flag_o <= dec_zero;
                end
                `MOPALU_OP_PWR_DOWN: begin
                    watchdog_clear_o        <= 1'b1;
                    power_down_flag_o       <= 1'b1;
                    watchdog_timeout_flag_o <= 1'b0;
                end
                `MOPALU_OP_INC_MEM: begin
                    mem_we_o           <= 1'b1;
                    mem_wdata_o        <= inc_res;
                    result_null_we_o   <= 1'b1;
                    result_null_flag_o <= inc_zero;
                end
                `MOPALU_OP_INC_WR: begin
                    working_register_o <= inc_res;
                    result_null_we_o   <= 1'b1;
                    result_null_flag_o <= inc_zero;
                end
                `MOPALU_OP_GOTO: begin
                    pc_o <= target_addr_i;
                end
                default: begin
                    mem_we_o <= 1'b0;
                end
            endcase
        end
    end
end

endmodule // mopalu_core

`default_nettype wire

// ### bench/mopalu_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************
// Port checker
// ****************************
module mopalu_core_sva (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        nrst_i,
    // Instruction issue
    input wire logic        op_valid_i,
    input wire logic [3:0]  op_code_i,
    input wire logic [11:0] target_addr_i,
    input wire logic [7:0]  mem_rdata_i,
    // Results
    input wire logic        mem_we_o,
    input wire logic [7:0]  mem_wdata_o,
    input wire logic [7:0]  working_register_o,
    input wire logic [11:0] pc_o,
    // Flags
    input wire logic        result_null_flag_o,
    input wire logic        result_null_we_o,
    input wire logic        overflow_out_we_o,
    input wire logic        power_down_flag_o,
    input wire logic        watchdog_timeout_flag_o,
    input wire logic        watchdog_clear_o,
    // Sequencing
    input wire logic        busy_o,
    input wire logic        clk_gate_off_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    wire logic t = op_valid_i & ~busy_o;
    property p_inv_mem; t && op_code_i == 4'h1 |=> mem_we_o && !overflow_out_we_o
        && mem_wdata_o == ~$past(mem_rdata_i); endproperty
    a_inv_mem: assert property (p_inv_mem) else $error("invert to memory wrong");
    property p_inv_wr; t && op_code_i == 4'h2 |=> !mem_we_o
        && working_register_o == ~$past(mem_rdata_i); endproperty
    a_inv_wr: assert property (p_inv_wr) else $error("invert to working wrong");
    property p_dec_mem; t && op_code_i == 4'h4 |=> mem_we_o
        && mem_wdata_o == $past(mem_rdata_i) - 8'h01; endproperty
    a_dec_mem: assert property (p_dec_mem) else $error("decrement memory wrong");
    property p_dec_wr; t && op_code_i == 4'h5 |=> !mem_we_o
        && working_register_o == $past(mem_rdata_i) - 8'h01; endproperty
    a_dec_wr: assert property (p_dec_wr) else $error("decrement working wrong");
    property p_inc_mem; t && op_code_i == 4'h7 |=> mem_we_o
        && mem_wdata_o == $past(mem_rdata_i) + 8'h01; endproperty
    a_inc_mem: assert property (p_inc_mem) else $error("increment memory wrong");
    property p_inc_wr; t && op_code_i == 4'h8 |=> !mem_we_o
        && working_register_o == $past(mem_rdata_i) + 8'h01; endproperty
    a_inc_wr: assert property (p_inc_wr) else $error("increment working wrong");
    property p_null; result_null_we_o |-> result_null_flag_o ==
        (mem_we_o ? mem_wdata_o == 8'h00 : working_register_o == 8'h00); endproperty
    a_null: assert property (p_null) else $error("zero flag wrong");
    property p_pwr; t && op_code_i == 4'h6 |=> watchdog_clear_o && power_down_flag_o
        && !watchdog_timeout_flag_o && clk_gate_off_o && busy_o && !mem_we_o; endproperty
    a_pwr: assert property (p_pwr) else $error("power down wrong");
    property p_goto; t && op_code_i == 4'h9 |=> pc_o == $past(target_addr_i) && busy_o
        ##1 !busy_o; endproperty
    a_goto: assert property (p_goto) else $error("goto wrong");
    property p_bcd; t && op_code_i == 4'h3 |=> mem_we_o && overflow_out_we_o
        && !result_null_we_o && $stable(working_register_o); endproperty
    a_bcd: assert property (p_bcd) else $error("decimal adjust wrong");
    property p_bcd_fix; t && op_code_i == 4'h3 |=> 8'(mem_wdata_o - $past(working_register_o))
        inside {8'h00, 8'h06, 8'h60, 8'h66}; endproperty
    a_bcd_fix: assert property (p_bcd_fix) else $error("decimal fix not a legal constant");
    property p_busy_quiet; busy_o |=> !mem_we_o && !result_null_we_o && !overflow_out_we_o
        && $stable(working_register_o); endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("write while busy");
    property p_refused; t && (op_code_i == 4'h0 || op_code_i > 4'h9) |=> !mem_we_o
        && !result_null_we_o && $stable(working_register_o) && $stable(pc_o); endproperty
    a_refused: assert property (p_refused) else $error("unused code changed state");
endmodule // mopalu_core_sva
bind mopalu_core mopalu_core_sva u_sva (.*);
`default_nettype wire

// ### bench/mopalu_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************
// Bench
// ****************************
module mopalu_core_tb;
    logic        ref_clk_i = 1'b0, nrst_i = 1'b0, op_valid_i = 1'b0, wake_i = 1'b0;
    logic        nibble_overflow_flag_i = 1'b0, overflow_out_flag_i = 1'b0;
    logic [3:0]  op_code_i = 4'h0;
    logic [11:0] target_addr_i = 12'h000, pc_o;
    logic [7:0]  mem_rdata_i = 8'h00, mem_wdata_o, working_register_o;
    logic        mem_we_o, result_null_flag_o, result_null_we_o, overflow_out_flag_o;
    logic        overflow_out_we_o, power_down_flag_o, watchdog_timeout_flag_o;
    logic        watchdog_clear_o, busy_o, clk_gate_off_o;
    int          n_errors = 0, samples_checked = 0;
    mopalu_core DUT (.*);
    initial forever #2 ref_clk_i = ~ref_clk_i;
    task chk(input logic [11:0] s, input logic [11:0] e);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task iss(input logic [3:0] op, input logic [7:0] m);
        @(posedge ref_clk_i) #1;
        op_valid_i = 1'b1; op_code_i = op; mem_rdata_i = m;
        @(posedge ref_clk_i) #1;
        op_valid_i = 1'b0; mem_rdata_i = ~m;
    endtask
    task arith(input logic [3:0] op, input logic [7:0] m, e, input logic tm);
        iss(op, m);
        chk(tm ? mem_wdata_o : working_register_o, e);
        chk(mem_we_o, tm);
        chk(result_null_flag_o, e == 8'h00);
        chk(result_null_we_o, 1'b1);
    endtask
    task bcd(input logic [7:0] w, input logic nf, cf, input logic [7:0] e, input logic eo);
        iss(4'h2, ~w);
        nibble_overflow_flag_i = nf; overflow_out_flag_i = cf;
        iss(4'h3, 8'h00);
        chk(mem_wdata_o, e);
        chk(overflow_out_flag_o, eo);
        chk(working_register_o, w);
        chk(result_null_we_o, 1'b0);
        chk(mem_we_o, 1'b1);
        chk(overflow_out_we_o, 1'b1);
    endtask
    task t_ops;
        arith(4'h1, 8'hFF, 8'h00, 1'b1);
        chk(overflow_out_we_o, 1'b0);
        arith(4'h2, 8'h5A, 8'hA5, 1'b0);
        arith(4'h7, 8'hFF, 8'h00, 1'b1);
        arith(4'h8, 8'h7F, 8'h80, 1'b0);
        arith(4'h4, 8'h00, 8'hFF, 1'b1);
        arith(4'h5, 8'h01, 8'h00, 1'b0);
        iss(4'hA, 8'h00);
        chk({mem_we_o, result_null_we_o, overflow_out_we_o}, 3'h0);
        chk(working_register_o, 8'h00);
        $display("ops test done");
    endtask
    task t_bcd;
        bcd(8'h9A, 1'b0, 1'b0, 8'h00, 1'b1);
        bcd(8'h38, 1'b1, 1'b0, 8'h3E, 1'b0);
        bcd(8'h45, 1'b0, 1'b0, 8'h45, 1'b0);
        bcd(8'h25, 1'b0, 1'b1, 8'h85, 1'b1);
        $display("bcd test done");
    endtask
    task t_flow;
        target_addr_i = 12'hABC;
        iss(4'h9, 8'h00);
        chk(pc_o, 12'hABC);
        chk(busy_o, 1'b1);
        @(posedge ref_clk_i) #1;
        chk(busy_o, 1'b0);
        iss(4'h6, 8'h00);
        chk({watchdog_clear_o, power_down_flag_o, watchdog_timeout_flag_o}, 3'h6);
        chk({busy_o, clk_gate_off_o}, 2'h3);
        iss(4'h7, 8'h10);
        chk(mem_we_o, 1'b0);
        wake_i = 1'b1;
        @(posedge ref_clk_i) #1;
        wake_i = 1'b0;
        chk({busy_o, clk_gate_off_o, power_down_flag_o}, 3'h1);
        chk(working_register_o, 8'h25);
        arith(4'h7, 8'h10, 8'h11, 1'b1);
        $display("flow test done");
    endtask
    task conclude;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge ref_clk_i);
        #1 nrst_i = 1'b1;
        t_ops();
        t_bcd();
        t_flow();
        conclude();
    end
endmodule // mopalu_core_tb
`default_nettype wire
